// ===== core/ascf_pkg.sv
// Shared constants and types for the accumulator-store, flag and interrupt command block
package ascf_pkg;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_ACCU_TO_AXIS = 8'h22;
  localparam logic [7:0] OP_ACCU_TO_GLOBAL = 8'h23;
  localparam logic [7:0] OP_CLEAR_FLAGS = 8'h24;
  localparam logic [7:0] OP_IRQ_ENABLE = 8'h19;
  localparam logic [7:0] OP_IRQ_DISABLE = 8'h1a;
  localparam logic [7:0] OP_VECTOR_DEFINE = 8'h25;
  localparam logic [7:0] OP_HANDLER_RETURN = 8'h26;

  // ----------------------------------------------------------------
  // Field values, positions and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] IRQ_ALL = 8'hff;
  localparam logic [7:0] STATUS_OK = 8'h64;
  localparam logic [7:0] CLR_ALL = 8'h00;
  localparam logic [7:0] CLR_SHUTDOWN = 8'h05;
  localparam int NUM_ERR = 5;
  localparam int ERR_TIMEOUT = 0;
  localparam int ERR_ALARM = 1;
  localparam int ERR_DEVIATION = 2;
  localparam int ERR_POSITION = 3;
  localparam int ERR_SHUTDOWN = 4;
  localparam logic [NUM_ERR-1:0] ERR_RESET = 5'h00;
  localparam logic [3:0] FRAME_LAST = 4'h8;
  localparam logic [3:0] FRAME_FIRST = 4'h0;
  localparam int PC_W = 16;

  // ----------------------------------------------------------------
  // Carried groups
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] typ;
    logic [7:0] bank;
    logic [31:0] value;
  } ascf_cmd_t;

  typedef struct packed {
    logic [7:0] host;
    logic [7:0] module_addr;
    logic [7:0] status;
    logic [7:0] op;
    logic [31:0] value;
    logic [7:0] checksum;
  } ascf_reply_t;

  typedef struct packed {
    logic [31:0] accu;
    logic [31:0] xreg;
    logic [7:0] flags;
    logic [PC_W-1:0] pc;
  } ascf_ctx_t;

endpackage

// ===== core/ascf_frame_rx.sv
// Nine-byte command frame assembler with address and checksum check
`timescale 1ns/1ps
`default_nettype none
module ascf_frame_rx import ascf_pkg::*; #(
  parameter logic [7:0] MODULE_ADDR = 8'h01
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Byte stream from the serial receiver
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  // Assembled frame
  output logic frame_valid,
  output ascf_cmd_t frame_cmd,
  output logic frame_bad
);

  logic [3:0] idx;
  logic [3:0] next_idx;
  logic [7:0] sum;
  logic [7:0] next_sum;
  logic [63:0] shreg;
  logic [63:0] next_shreg;
  logic next_frame_valid;
  logic next_frame_bad;
  ascf_cmd_t next_frame_cmd;

  // ----------------------------------------------------------------
  // Byte collection; last byte is the checksum
  // ----------------------------------------------------------------
  always_comb begin
    next_idx = idx;
    next_sum = sum;
    next_shreg = shreg;
    next_frame_valid = 1'b0;
    next_frame_bad = 1'b0;
    next_frame_cmd = frame_cmd;
    if (rx_valid) begin
      if (idx == FRAME_LAST) begin
        next_idx = FRAME_FIRST;
        next_sum = 8'h00;
        // Modulo-256 sum of the eight leading bytes must match
        if (rx_byte != sum) begin
          next_frame_bad = 1'b1;
        end else if (shreg[63:56] == MODULE_ADDR) begin
          next_frame_valid = 1'b1;
          // Address, op, type, bank, then value most significant first
          next_frame_cmd = ascf_cmd_t'(shreg[55:0]);
        end
      end else begin
        next_idx = idx + 4'h1;
        next_sum = sum + rx_byte;
        next_shreg = {shreg[55:0], rx_byte};
      end
    end
  end

  // Register stage
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      idx <= FRAME_FIRST;
      sum <= 8'h00;
      shreg <= 64'h0;
      frame_valid <= 1'b0;
      frame_bad <= 1'b0;
      frame_cmd <= '0;
    end else begin
      idx <= next_idx;
      sum <= next_sum;
      shreg <= next_shreg;
      frame_valid <= next_frame_valid;
      frame_bad <= next_frame_bad;
      frame_cmd <= next_frame_cmd;
    end
  end

  // A wrong checksum raises the flag and the frame never reaches the executor
  chk_bad_frame_dropped: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (rx_valid && idx == FRAME_LAST && rx_byte != sum) |=> frame_bad && !frame_valid)
    else $error("bad checksum frame not dropped");

endmodule
`default_nettype wire

// ===== core/ascf_cmd.sv
// Executor for accumulator stores, error-flag clear and interrupt control commands
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Code 34 stores accumulator to axis parameter
// - Code 35 stores accumulator to global parameter
// - Code 36 clears flags chosen by type
// - Type 0 clears every error flag
// - Types 1-4 clear timeout, alarm, deviation, position
// - Type 5 clears only shutdown flag
// - Code 25 enables the numbered interrupt source
// - Enable number 255 sets global enable
// - Code 26 disables the numbered interrupt source
// - Disable number 255 clears global enable
// - Vector command records handler entry address
// - Redefining a vector overwrites stored address
// - Frame: address, op, type, bank, value, checksum
// - Direct commands reply with status 100
// - Vector command decoded from code 37
// - Handler return restores saved program context
module ascf_cmd import ascf_pkg::*; #(
  parameter int NUM_IRQ = 16,
  parameter logic [7:0] MODULE_ADDR = 8'h01,
  parameter logic [7:0] HOST_ADDR = 8'h02
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Byte stream from the serial receiver (same clock)
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  // Commands from the stored program
  input wire logic prog_valid,
  input wire ascf_cmd_t prog_cmd,
  // Live program context and event sources
  input wire ascf_ctx_t ctx_now,
  input wire logic [NUM_ERR-1:0] err_set,
  input wire logic [NUM_IRQ-1:0] irq_req,
  // Parameter store port
  output logic axis_wr,
  output logic global_wr,
  output logic [7:0] param_sel,
  output logic [7:0] param_bank,
  output logic [31:0] param_value,
  // Status and interrupt control
  output logic [NUM_ERR-1:0] err_flags,
  output logic [NUM_IRQ-1:0] irq_src_en,
  output logic irq_global_en,
  output logic in_handler,
  output logic irq_take,
  output logic [7:0] irq_num,
  output logic [PC_W-1:0] irq_entry,
  output logic ctx_restore,
  output ascf_ctx_t ctx_saved,
  // Reply and link status
  output logic reply_valid,
  output ascf_reply_t reply,
  output logic frame_bad
);

  typedef enum logic [1:0] {
    ST_NORMAL = 2'b01,
    ST_HANDLER = 2'b10
  } ascf_state_t;

  // Interrupt numbers beyond the table are dropped silently
  function automatic logic irq_in_range(input logic [7:0] n);
    irq_in_range = (32'(n) < NUM_IRQ);
  endfunction

  // Mask of flags a clear command removes
  function automatic logic [NUM_ERR-1:0] clear_mask(input logic [7:0] t);
    logic [NUM_ERR-1:0] m;
    m = '0;
    if (t == CLR_ALL) begin
      m = '1;
    end else if (t <= CLR_SHUTDOWN) begin
      m[3'(t - 8'h01)] = 1'b1;
    end
    clear_mask = m;
  endfunction

  logic dir_valid;
  ascf_cmd_t dir_cmd;

  // ----------------------------------------------------------------
  // Frame front end
  // ----------------------------------------------------------------
  ascf_frame_rx #(.MODULE_ADDR(MODULE_ADDR)) u_rx (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .rx_byte(rx_byte),
    .rx_valid(rx_valid),
    .frame_valid(dir_valid),
    .frame_cmd(dir_cmd),
    .frame_bad(frame_bad)
  );

  ascf_state_t state;
  ascf_state_t next_state;
  logic [PC_W-1:0] vec_addr [NUM_IRQ];
  logic [PC_W-1:0] next_vec_addr [NUM_IRQ];
  logic [NUM_IRQ-1:0] vec_ok;
  logic [NUM_IRQ-1:0] next_vec_ok;
  logic next_axis_wr;
  logic next_global_wr;
  logic [7:0] next_param_sel;
  logic [7:0] next_param_bank;
  logic [31:0] next_param_value;
  logic [NUM_ERR-1:0] next_err_flags;
  logic [NUM_IRQ-1:0] next_irq_src_en;
  logic next_irq_global_en;
  logic next_irq_take;
  logic [7:0] next_irq_num;
  logic [PC_W-1:0] next_irq_entry;
  logic next_ctx_restore;
  ascf_ctx_t next_ctx_saved;
  logic next_reply_valid;
  ascf_reply_t next_reply;

  // ----------------------------------------------------------------
  // Command execution and interrupt dispatch
  // ----------------------------------------------------------------
  // Direct frames win a collision; the program command is then lost,
  // which keeps the path single-cycle at the cost of a sequencing rule.
  always_comb begin
    ascf_cmd_t c;
    logic exec;
    logic known;
    logic [NUM_ERR-1:0] clr;
    logic found;
    c = dir_valid ? dir_cmd : prog_cmd;
    exec = dir_valid | prog_valid;
    known = 1'b0;
    clr = '0;
    found = 1'b0;
    next_state = state;
    next_vec_addr = vec_addr;
    next_vec_ok = vec_ok;
    next_axis_wr = 1'b0;
    next_global_wr = 1'b0;
    next_param_sel = param_sel;
    next_param_bank = param_bank;
    next_param_value = param_value;
    next_irq_src_en = irq_src_en;
    next_irq_global_en = irq_global_en;
    next_irq_take = 1'b0;
    next_irq_num = irq_num;
    next_irq_entry = irq_entry;
    next_ctx_restore = 1'b0;
    next_ctx_saved = ctx_saved;
    next_reply_valid = 1'b0;
    next_reply = reply;
    if (exec) begin
      known = 1'b1;
      unique case (c.op)
        OP_ACCU_TO_AXIS, OP_ACCU_TO_GLOBAL: begin
          // Accumulator is taken as the program left it
          next_axis_wr = (c.op == OP_ACCU_TO_AXIS);
          next_global_wr = (c.op == OP_ACCU_TO_GLOBAL);
          next_param_sel = c.typ;
          next_param_bank = c.bank;
          next_param_value = ctx_now.accu;
        end
        OP_CLEAR_FLAGS: clr = clear_mask(c.typ);
        OP_IRQ_ENABLE: begin
          if (c.typ == IRQ_ALL) begin
            next_irq_global_en = 1'b1;
          end else if (irq_in_range(c.typ)) begin
            next_irq_src_en[c.typ[$clog2(NUM_IRQ)-1:0]] = 1'b1;
          end
        end
        OP_IRQ_DISABLE: begin
          if (c.typ == IRQ_ALL) begin
            next_irq_global_en = 1'b0;
          end else if (irq_in_range(c.typ)) begin
            next_irq_src_en[c.typ[$clog2(NUM_IRQ)-1:0]] = 1'b0;
          end
        end
        OP_VECTOR_DEFINE: begin
          // Accepted from either source; host use is the host's own fault
          if (irq_in_range(c.typ)) begin
            next_vec_addr[c.typ[$clog2(NUM_IRQ)-1:0]] = c.value[PC_W-1:0];
            next_vec_ok[c.typ[$clog2(NUM_IRQ)-1:0]] = 1'b1;
          end
        end
        OP_HANDLER_RETURN: begin
          if (state == ST_HANDLER) begin
            next_ctx_restore = 1'b1;
          end
        end
        default: known = 1'b0;
      endcase
    end
    // Reply for every handled direct command
    if (dir_valid && known) begin
      next_reply_valid = 1'b1;
      next_reply.host = HOST_ADDR;
      next_reply.module_addr = MODULE_ADDR;
      next_reply.status = STATUS_OK;
      next_reply.op = c.op;
      next_reply.value = 32'h0;
      next_reply.checksum = HOST_ADDR + MODULE_ADDR + STATUS_OK + c.op;
    end
    // Hardware setting wins over a clear in the same cycle
    next_err_flags = (err_flags & ~clr) | err_set;
    unique case (state)
      ST_NORMAL: begin
        // Lowest numbered eligible source is served first
        for (int i = 0; i < NUM_IRQ; i++) begin
          if (!found && irq_global_en && irq_src_en[i] && vec_ok[i] && irq_req[i]) begin
            found = 1'b1;
            next_irq_take = 1'b1;
            next_irq_num = 8'(i);
            next_irq_entry = vec_addr[i];
            next_ctx_saved = ctx_now;
          end
        end
        if (found) begin
          next_state = ST_HANDLER;
        end
      end
      ST_HANDLER: begin
        if (next_ctx_restore) begin
          next_state = ST_NORMAL;
        end
      end
      default: next_state = ST_NORMAL;
    endcase
  end

  // Register stage
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_NORMAL;
      vec_addr <= '{default: '0};
      vec_ok <= '0;
      axis_wr <= 1'b0;
      global_wr <= 1'b0;
      param_sel <= 8'h00;
      param_bank <= 8'h00;
      param_value <= 32'h0;
      err_flags <= ERR_RESET;
      irq_src_en <= '0;
      irq_global_en <= 1'b0;
      in_handler <= 1'b0;
      irq_take <= 1'b0;
      irq_num <= 8'h00;
      irq_entry <= '0;
      ctx_restore <= 1'b0;
      ctx_saved <= '0;
      reply_valid <= 1'b0;
      reply <= '0;
    end else begin
      state <= next_state;
      vec_addr <= next_vec_addr;
      vec_ok <= next_vec_ok;
      axis_wr <= next_axis_wr;
      global_wr <= next_global_wr;
      param_sel <= next_param_sel;
      param_bank <= next_param_bank;
      param_value <= next_param_value;
      err_flags <= next_err_flags;
      irq_src_en <= next_irq_src_en;
      irq_global_en <= next_irq_global_en;
      in_handler <= (next_state == ST_HANDLER);
      irq_take <= next_irq_take;
      irq_num <= next_irq_num;
      irq_entry <= next_irq_entry;
      ctx_restore <= next_ctx_restore;
      ctx_saved <= next_ctx_saved;
      reply_valid <= next_reply_valid;
      reply <= next_reply;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_axis_store_accu: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (dir_valid && dir_cmd.op == OP_ACCU_TO_AXIS) |=> axis_wr && !global_wr
      && param_value == $past(ctx_now.accu) && param_sel == $past(dir_cmd.typ))
    else $error("axis store did not carry accumulator");
  chk_global_store_bank: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (dir_valid && dir_cmd.op == OP_ACCU_TO_GLOBAL) |=>
      global_wr && !axis_wr && param_bank == $past(dir_cmd.bank))
    else $error("global store missing or wrong bank");
  chk_clear_all_flags: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (dir_valid && dir_cmd.op == OP_CLEAR_FLAGS && dir_cmd.typ == CLR_ALL && err_set == '0)
      |=> err_flags == '0)
    else $error("clear-all left a flag set");
  chk_clear_timeout_only: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (dir_valid && dir_cmd.op == OP_CLEAR_FLAGS && dir_cmd.typ == 8'h01) |=>
      err_flags[NUM_ERR-1:1] == ($past(err_flags[NUM_ERR-1:1]) | $past(err_set[NUM_ERR-1:1]))
      && err_flags[ERR_TIMEOUT] == $past(err_set[ERR_TIMEOUT]))
    else $error("timeout clear touched another flag");
  chk_clear_shutdown_only: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (dir_valid && dir_cmd.op == OP_CLEAR_FLAGS && dir_cmd.typ == CLR_SHUTDOWN) |=>
      err_flags[ERR_POSITION:0]
        == ($past(err_flags[ERR_POSITION:0]) | $past(err_set[ERR_POSITION:0]))
      && err_flags[ERR_SHUTDOWN] == $past(err_set[ERR_SHUTDOWN]))
    else $error("shutdown clear touched another flag");
  chk_global_enable: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (dir_valid && dir_cmd.typ == IRQ_ALL
      && (dir_cmd.op == OP_IRQ_ENABLE || dir_cmd.op == OP_IRQ_DISABLE))
      |=> irq_global_en == ($past(dir_cmd.op) == OP_IRQ_ENABLE) && $stable(irq_src_en))
    else $error("global enable not set or cleared");
  // Any in-range source number, so the host's own choice of source is covered
  chk_source_enable: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (dir_valid && irq_in_range(dir_cmd.typ)
      && (dir_cmd.op == OP_IRQ_ENABLE || dir_cmd.op == OP_IRQ_DISABLE))
      |=> irq_src_en[$past(dir_cmd.typ[$clog2(NUM_IRQ)-1:0])]
        == ($past(dir_cmd.op) == OP_IRQ_ENABLE) && $stable(irq_global_en))
    else $error("source enable not updated");
  chk_direct_reply: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (dir_valid && dir_cmd.op == OP_CLEAR_FLAGS) |=> reply_valid && reply.status == STATUS_OK
      ##1 !reply_valid || $past(dir_valid))
    else $error("direct command reply missing or wrong");
  // Gate is judged on the source picked one cycle before the take pulse
  chk_dispatch_gate: assert property (@(posedge clk_sys) disable iff (!reset_n)
    irq_take |-> in_handler
      && $past(irq_global_en && irq_src_en[next_irq_num[$clog2(NUM_IRQ)-1:0]]))
    else $error("interrupt taken while disabled");
  chk_restore_context: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ctx_restore |-> !in_handler && $past(in_handler))
    else $error("context restore outside a handler");

endmodule
`default_nettype wire

// ===== verif/ascf_host_model.sv
// Host model that sends nine-byte command frames to the block
`timescale 1ns/1ps
`default_nettype none
module ascf_host_model (
  // Clock
  input wire logic clk_sys,
  // Byte stream to the block
  output var logic [7:0] rx_byte,
  output var logic rx_valid
);
  // -------------------------------------------------------------
  // Idle line
  // -------------------------------------------------------------
  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
  end

  // -------------------------------------------------------------
  // Frame sender
  // -------------------------------------------------------------
  // Bytes go out back to back, value most significant first
  task automatic send(input logic [7:0] adr, input logic [7:0] op, input logic [7:0] typ,
                      input logic [7:0] bank, input logic [31:0] val, input logic bad);
    logic [71:0] f;
    logic [7:0] sum;
    f = {adr, op, typ, bank, val, 8'h00};
    sum = 8'h00;
    for (int i = 0; i < 8; i++) begin
      sum = sum + f[71-8*i -: 8];
    end
    f[7:0] = bad ? sum + 8'h01 : sum;
    for (int i = 0; i < 9; i++) begin
      @(posedge clk_sys);
      rx_byte <= f[71-8*i -: 8];
      rx_valid <= 1'b1;
    end
    // Released line shows the inverse so a stale byte never looks valid
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_byte <= ~f[7:0];
  endtask
endmodule
`default_nettype wire

// ===== verif/ascf_cmd_bench.sv
// Self-checking bench for the command executor
`timescale 1ns/1ps
`default_nettype none
module ascf_cmd_bench import ascf_pkg::*;;
  logic clk_sys, reset_n, rx_valid, prog_valid, axis_wr, global_wr, in_handler;
  logic irq_global_en, irq_take, ctx_restore, reply_valid, frame_bad;
  logic [7:0] rx_byte, param_sel, param_bank, irq_num;
  logic [31:0] param_value, va, vb;
  logic [NUM_ERR-1:0] err_set, err_flags, ef;
  logic [15:0] irq_req, irq_src_en;
  logic [PC_W-1:0] irq_entry;
  ascf_cmd_t prog_cmd;
  ascf_ctx_t ctx_now, ctx_saved, ctx_old;
  ascf_reply_t reply;
  logic [49:0] sq[$];
  logic [71:0] rq[$];
  logic [7:0] t, b;
  int fails, n_tests, n_bad, n_take, n_rest;

  ascf_cmd DUT (
    .clk_sys(clk_sys), .reset_n(reset_n), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .prog_valid(prog_valid), .prog_cmd(prog_cmd), .ctx_now(ctx_now), .err_set(err_set),
    .irq_req(irq_req), .axis_wr(axis_wr), .global_wr(global_wr), .param_sel(param_sel),
    .param_bank(param_bank), .param_value(param_value), .err_flags(err_flags),
    .irq_src_en(irq_src_en), .irq_global_en(irq_global_en), .in_handler(in_handler),
    .irq_take(irq_take), .irq_num(irq_num), .irq_entry(irq_entry),
    .ctx_restore(ctx_restore), .ctx_saved(ctx_saved), .reply_valid(reply_valid),
    .reply(reply), .frame_bad(frame_bad)
  );

  ascf_host_model host (.clk_sys(clk_sys), .rx_byte(rx_byte), .rx_valid(rx_valid));

  // -------------------------------------------------------------
  // Clock and checking helpers
  // -------------------------------------------------------------
  always #12.5 clk_sys = ~clk_sys;

  task automatic chk(input string nm, input logic [87:0] e, input logic [87:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Direct frame; the reply note is queued before the frame goes out
  task automatic dir(input logic [7:0] op, input logic [7:0] typ, input logic [31:0] v);
    rq.push_back({8'h02, 8'h01, STATUS_OK, op, 32'h0, 8'h67 + op});
    host.send(8'h01, op, typ, b, v, 1'b0);
    repeat (3) @(posedge clk_sys);
  endtask

  // Stored-program command, one-cycle strobe
  task automatic prg(input logic [7:0] op, input logic [7:0] typ, input logic [31:0] v);
    @(posedge clk_sys);
    prog_valid <= 1'b1;
    prog_cmd <= '{op: op, typ: typ, bank: b, value: v};
    @(posedge clk_sys);
    prog_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  // -------------------------------------------------------------
  // Result watcher: each pulse takes the oldest note
  // -------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (reset_n === 1'b1) begin
      if ((axis_wr || global_wr) !== 1'b0) begin
        chk("store", sq.size() ? sq.pop_front() : 50'h0,
            {axis_wr, global_wr, param_sel, param_bank, param_value});
      end
      if (reply_valid === 1'b1) begin
        chk("reply", rq.size() ? rq.pop_front() : 72'h0, reply);
      end
      if (frame_bad === 1'b1) n_bad++;
      if (irq_take === 1'b1) n_take++;
      if (ctx_restore === 1'b1) n_rest++;
    end
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    final_report();
  end

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    reset_n = 1'b0;
    prog_valid = 1'b0;
    prog_cmd = '0;
    ctx_now = '0;
    err_set = '0;
    irq_req = '0;
    b = 8'h00;
    void'($urandom(32'hb1475fc8));
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    // Global enable from the host
    dir(OP_IRQ_ENABLE, IRQ_ALL, 32'h0);
    chk("global_en", 88'h1, irq_global_en);
    // Corrupt checksum, then a frame for another module: only the first raises frame_bad, neither changes the global enable
    host.send(8'h01, OP_IRQ_DISABLE, IRQ_ALL, 8'h00, 32'h0, 1'b1);
    host.send(8'h05, OP_IRQ_DISABLE, IRQ_ALL, 8'h00, 32'h0, 1'b0);
    repeat (3) @(posedge clk_sys);
    chk("bad_count", 88'h1, n_bad);
    chk("global_kept", 88'h1, irq_global_en);
    // Both stores from both sources with a random accumulator
    for (int k = 0; k < 4; k++) begin
      ctx_now.accu <= $urandom;
      t = $urandom;
      b = $urandom;
      @(posedge clk_sys);
      sq.push_back({k[0] == 1'b0, k[0] == 1'b1, t, b, ctx_now.accu});
      if (k[1]) dir(k[0] ? OP_ACCU_TO_GLOBAL : OP_ACCU_TO_AXIS, t, $urandom);
      else prg(k[0] ? OP_ACCU_TO_GLOBAL : OP_ACCU_TO_AXIS, t, $urandom);
    end
    // Every clear type after setting all flags; type 6 clears nothing
    for (int k = 0; k < 7; k++) begin
      @(posedge clk_sys);
      err_set <= 5'h1f;
      @(posedge clk_sys);
      err_set <= 5'h00;
      b = $urandom;
      dir(OP_CLEAR_FLAGS, k[7:0], $urandom);
      ef = (k == 0) ? 5'h00 : (k < 6) ? 5'h1f & ~(5'h01 << (k - 1)) : 5'h1f;
      chk("err_flags", {83'h0, ef}, err_flags);
    end
    // Single source enable and disable
    b = 8'h00;
    dir(OP_IRQ_ENABLE, 8'h03, $urandom);
    chk("src_en", 88'h8, irq_src_en);
    dir(OP_IRQ_DISABLE, 8'h03, $urandom);
    chk("src_off", 88'h0, irq_src_en);
    // Vector defined then redefined; no dispatch while globally off
    va = $urandom;
    vb = $urandom;
    prg(OP_VECTOR_DEFINE, 8'h03, va);
    prg(OP_VECTOR_DEFINE, 8'h03, vb);
    prg(OP_IRQ_ENABLE, 8'h03, 32'h0);
    dir(OP_IRQ_DISABLE, IRQ_ALL, 32'h0);
    chk("global_off", 88'h0, irq_global_en);
    ctx_now <= {$urandom, $urandom, 8'h5a, 16'h1234};
    irq_req <= 16'h0008;
    repeat (6) @(posedge clk_sys);
    chk("no_take", 88'h0, n_take);
    ctx_old = ctx_now;
    prg(OP_IRQ_ENABLE, IRQ_ALL, 32'h0);
    for (int i = 0; i < 20 && n_take == 0; i++) @(posedge clk_sys);
    irq_req <= 16'h0;
    chk("take", 88'h1, n_take);
    chk("irq_num", 88'h3, irq_num);
    chk("irq_entry", {72'h0, vb[15:0]}, irq_entry);
    chk("ctx_saved", ctx_old, ctx_saved);
    chk("in_handler", 88'h1, in_handler);
    // Handler return restores the saved context
    ctx_now <= {$urandom, $urandom, 8'ha5, 16'h4321};
    prg(OP_HANDLER_RETURN, IRQ_ALL, 32'h0);
    chk("restore", 88'h1, n_rest);
    chk("left_handler", 88'h0, in_handler);
    chk("ctx_held", ctx_old, ctx_saved);
    chk("notes_left", 88'h0, sq.size() + rq.size());
    final_report();
  end
endmodule
`default_nettype wire
